// ==== front_end_model.sv ====
/* front end model: answers each convert pulse with one sample.
   assumes conv_start and conv_sel from the sequencer on mclk_in. */
`timescale 1ns/100ps
module front_end_model (
  input wire logic mclk_in,
  input wire logic conv_start_in,
  input wire logic [4:0] conv_sel_in,
  input wire logic [15:0] die_val_in,
  input wire logic [15:0] step_in,
  output logic sample_valid_out,
  output logic [15:0] sample_data_out
);
  logic [1:0] wait_reg = 2'h0;
  initial begin
    sample_valid_out = 1'b0;
    sample_data_out = 16'h0000;
  end
  // data means nothing without the strobe, so it toggles in between
  always @(posedge mclk_in) begin
    wait_reg <= {wait_reg[0], conv_start_in === 1'b1};
    sample_valid_out <= wait_reg[1];
    if (wait_reg[1])
      sample_data_out <= (conv_sel_in == 5'h00) ? die_val_in
        : {3'h0, conv_sel_in, 8'h5A} + step_in;
    else
      sample_data_out <= ~sample_data_out;
  end
endmodule // front_end_model

// ==== lpf_step.sv ====
/*
  One step of a single-pole low-pass filter, y += (x - y) * 2^-(shift+1).
  Assumes a caller that holds the state with F fraction bits.
*/
`timescale 1ns/100ps
module lpf_step #(
  parameter int W = 16,
  parameter int F = 8
) (
  input wire logic [W-1:0] sample_in,
  input wire logic [W+F-1:0] state_in,
  input wire logic [2:0] shift_in,
  input wire logic prime_in,
  output logic [W+F-1:0] state_out,
  output logic [W-1:0] result_out
);
  logic signed [W+F:0] diff;
  logic signed [W+F:0] step;

  always_comb begin
    diff = $signed({sample_in[W-1], sample_in, {F{1'b0}}}) - $signed({state_in[W+F-1], state_in});
    step = diff >>> (shift_in + 3'h1);
    if (prime_in) begin
      state_out = {sample_in, {F{1'b0}}};
    end else begin
      state_out = state_in + step[W+F-1:0];
    end
    result_out = state_out[W+F-1:F];
  end
endmodule // lpf_step

// ==== main_adc_defines.svh ====
/*
  Constants of the main converter round-robin sequencer: timing, slot map,
  register offsets and field positions.
  Assumes it is included by bare name into each design file that needs it.
*/
`ifndef MAIN_ADC_DEFINES_SVH
`define MAIN_ADC_DEFINES_SVH
// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS 5
`define SLOT_TIME_NS 8000
`define SLOT_CYCLES (`SLOT_TIME_NS / `CLK_PERIOD_NS)
`define DLY_UNIT_NS 1000
`define DLY_UNIT_CYCLES (`DLY_UNIT_NS / `CLK_PERIOD_NS)
`define DECIDE_TICK 1
// ****************************************************************
// slot map
// ****************************************************************
`define NUM_SLOTS 24
`define SLOT_DIE 5'h00
`define SLOT_THERMISTOR_BIAS_REFERENCE 5'h01
`define SLOT_CELL1 5'h02
`define SLOT_CELL16 5'h11
`define SLOT_BUSBAR 5'h12
`define SLOT_GPIO 5'h13
`define SLOT_LAST 5'h17
`define GPIO_BASE_IDX 5'h18
`define FILT_BASE 5'h02
`define RESULT_DEFAULT 16'h8000
`define RR_BURST_LAST 4'h7
`define MIN_CELLS 5'h06
`define MAX_CELLS 5'h10
`define CUTOFF_MAX 3'h6
`define FRAC_BITS 8
// ****************************************************************
// register map
// ****************************************************************
`define OFS_CTRL 12'h000
`define OFS_CONF 12'h004
`define OFS_ACTIVE 12'h008
`define OFS_GPIOCFG 12'h00C
`define OFS_STATUS 12'h010
`define RESULT_PAGE 4'h1
`define CTRL_GO 0
`define CTRL_MODE_LSB 1
`define CTRL_MODE_MSB 2
`define CTRL_CELL_LPF 3
`define CTRL_BB_LPF 4
`define CONF_CELL_LSB 0
`define CONF_CELL_MSB 2
`define CONF_BB_LSB 4
`define CONF_BB_MSB 6
`define CONF_DLY_LSB 8
`define CONF_DLY_MSB 13
`define MODE_STOP 2'h0
`define MODE_BURST 2'h1
`define MODE_CONT 2'h2
`endif

// ==== main_adc_pkg.sv ====
/*
  Types shared by the main converter sequencer.
  Assumes nothing of its surroundings.
*/
package main_adc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_CLEAR = 3'h1,
    ST_DELAY = 3'h3,
    ST_WAIT  = 3'h2,
    ST_MEAS  = 3'h6,
    ST_STORE = 3'h7
  } seq_state_t;
endpackage

// ==== main_adc_round_robin_lpf.sv ====
/*
  Main converter round-robin sequencer with result registers, read lock and
  post-conversion low-pass filters, reached over APB.
  Assumes a front end on mclk_in that answers conv_start_out with one
  sample_valid_in pulse at least one cycle later, within the same slot.
*/
// Our own choices: the register addresses and register access over APB.
// Notes on behaviour
// - 24 slots repeat, 8 us each, 192 us per cycle.
// - slots: die temp, thermistor reference, 16 cells, bus bar, GPIO, spares.
// - one GPIO per cycle, next GPIO each cycle, eight cycles cover all.
// - results are signed 16-bit, split in high and low byte registers.
// - on enable every result register is loaded with 0x8000 first.
// - a result is written as soon as its slot's conversion completes.
// - after a high byte read the low byte stays frozen until read.
// - die temperature signed around zero, saturated at +200 and -100 C.
// - six to sixteen series cells are supported.
// - cells at or below the highest active setting are measured, others not.
// - skipped slots keep their time, so cycle length never changes.
// - inactive cell results keep 0x8000 and are never written.
// - cells store raw conversion, or filtered value when filter enabled.
// - 3-bit cutoff picks one of seven, same for every cell.
// - single pole, coefficient one half down to 1/128 by cutoff.
// - filtered values only effective in continuous running.
// - a filter newly enabled starts from its first sample.
// - bus bar filter has own cutoff field and enable.
// - bus bar stores raw or filtered value by its enable.
// - die temperature also feeds gain and offset correction.
// - cell level shifters are off in sleep or shutdown.
// - main converter control is independent of the auxiliary one.
// - start latches mode, filters, delay and channel settings.
// - mode 00 stop, 01 eight cycles then stop, 10 continuous.
`timescale 1ns/100ps
`include "main_adc_defines.svh"
module main_adc_round_robin_lpf
  import main_adc_pkg::*;
#(
  parameter int SLOT_CYC = `SLOT_CYCLES,
  parameter logic signed [15:0] DIE_CODE_MAX = 16'sh7000,
  parameter logic signed [15:0] DIE_CODE_MIN = 16'shC800
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  input wire logic sample_valid_in,
  input wire logic [15:0] sample_data_in,
  input wire logic low_power_in,
  output logic conv_start_out,
  output logic [4:0] conv_sel_out,
  output logic [2:0] gpio_sel_out,
  output logic [15:0] level_shift_en_out,
  output logic [15:0] die_temp_corr_out,
  output logic die_temp_corr_valid_out
);
  localparam int TW = $clog2(SLOT_CYC);
  localparam int FW = 16 + `FRAC_BITS;
  localparam logic [TW-1:0] TICK_LAST = TW'(SLOT_CYC - 1);
  localparam logic [TW-1:0] TICK_DECIDE = TW'(`DECIDE_TICK);

  typedef struct packed {
    seq_state_t st;
    logic [4:0] slot;
    logic [TW-1:0] tick;
    logic [3:0] rr_cnt;
    logic [2:0] gpio_idx;
    logic [1:0] mode;
    logic cell_lpf;
    logic bb_lpf;
    logic [2:0] cell_cut;
    logic [2:0] bb_cut;
    logic [4:0] hi_cell;
    logic [7:0] gpio_en;
    logic [15:0] dly;
    logic [4:0] clr_idx;
    logic [16:0] primed;
    logic [4:0] wr_idx;
    logic [15:0] sample;
    logic [FW-1:0] fstate;
    logic wr_filt;
    logic [4:0] sw_ctrl;
    logic [13:0] sw_conf;
    logic [3:0] sw_active;
    logic [7:0] sw_gpio;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic hold_v;
    logic [4:0] hold_idx;
    logic [7:0] hold_byte;
    logic conv_start;
    logic [4:0] conv_sel;
    logic [2:0] gpio_sel;
    logic [15:0] lvl_en;
    logic [15:0] die_corr;
    logic die_corr_v;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic running;
  logic boundary;
  logic is_cell;
  logic measure;
  logic [4:0] cell_num;
  logic [4:0] res_idx;
  logic acc;
  logic res_page;
  logic res_rd;
  logic go_wr;
  logic res_we;
  logic [4:0] res_waddr;
  logic [15:0] res_wdata;
  logic [15:0] res_rdata;
  logic [FW-1:0] filt_rdata;
  logic [FW-1:0] filt_new;
  logic [15:0] filt_res;
  logic [4:0] pidx;
  logic [4:0] lvl_hi;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [4:0] hi_from_field(input logic [3:0] f);
    logic [4:0] v;
    v = {1'b0, f};
    if (f == 4'h0) begin
      v = `MAX_CELLS;
    end else if (v < `MIN_CELLS) begin
      v = `MIN_CELLS;
    end
    return v;
  endfunction

  function automatic logic [2:0] cut_clamp(input logic [2:0] c);
    return (c > `CUTOFF_MAX) ? `CUTOFF_MAX : c;
  endfunction

  function automatic logic [15:0] die_sat(input logic [15:0] x);
    logic [15:0] v;
    v = x;
    if ($signed(x) > DIE_CODE_MAX) begin
      v = DIE_CODE_MAX;
    end else if ($signed(x) < DIE_CODE_MIN) begin
      v = DIE_CODE_MIN;
    end
    return v;
  endfunction

  assign running = (s_reg.st == ST_WAIT) || (s_reg.st == ST_MEAS) || (s_reg.st == ST_STORE);
  assign boundary = running && (s_reg.tick == TICK_LAST);
  assign is_cell = (s_reg.slot >= `SLOT_CELL1) && (s_reg.slot <= `SLOT_CELL16);
  assign cell_num = s_reg.slot - 5'h01;
  // spare slots and unconfigured inputs are never converted
  assign measure = (s_reg.slot == `SLOT_DIE) || (s_reg.slot == `SLOT_THERMISTOR_BIAS_REFERENCE)
    || (is_cell && (cell_num <= s_reg.hi_cell))
    || (s_reg.slot == `SLOT_BUSBAR)
    || ((s_reg.slot == `SLOT_GPIO) && s_reg.gpio_en[s_reg.gpio_idx]);
  assign res_idx = (s_reg.slot == `SLOT_GPIO) ? (`GPIO_BASE_IDX + {2'h0, s_reg.gpio_idx})
    : s_reg.slot;
  assign acc = psel_in && penable_in && !s_reg.pready;
  assign res_page = (paddr_in[11:8] == `RESULT_PAGE) && (paddr_in[1:0] == 2'h0);
  assign res_rd = acc && res_page && !pwrite_in;
  assign go_wr = acc && pwrite_in && (paddr_in == `OFS_CTRL) && pwdata_in[`CTRL_GO];
  assign pidx = s_reg.wr_idx - `FILT_BASE;
  assign lvl_hi = hi_from_field(s_reg.sw_active);

  // ****************************************************************
  // result and filter storage
  // ****************************************************************
  assign res_we = (s_reg.st == ST_CLEAR) || (s_reg.st == ST_STORE);
  assign res_waddr = (s_reg.st == ST_CLEAR) ? s_reg.clr_idx : s_reg.wr_idx;
  assign res_wdata = (s_reg.st == ST_CLEAR) ? `RESULT_DEFAULT
    : (s_reg.wr_filt ? filt_res : s_reg.sample);

  sample_ram #(.W(16), .AW(5)) u_results (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .wr_en_in(res_we),
    .wr_addr_in(res_waddr),
    .wr_data_in(res_wdata),
    .rd_addr_in(paddr_in[7:3]),
    .rd_data_out(res_rdata)
  );

  sample_ram #(.W(FW), .AW(5)) u_filters (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .wr_en_in((s_reg.st == ST_STORE) && s_reg.wr_filt),
    .wr_addr_in(s_reg.wr_idx),
    .wr_data_in(filt_new),
    .rd_addr_in(s_reg.slot),
    .rd_data_out(filt_rdata)
  );

  lpf_step #(.W(16), .F(`FRAC_BITS)) u_lpf (
    .sample_in(s_reg.sample),
    .state_in(s_reg.fstate),
    .shift_in((s_reg.wr_idx == `SLOT_BUSBAR) ? s_reg.bb_cut : s_reg.cell_cut),
    .prime_in(!s_reg.primed[pidx]),
    .state_out(filt_new),
    .result_out(filt_res)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    s_next.conv_start = 1'b0;
    for (int i = 0; i < 16; i++) begin
      s_next.lvl_en[i] = !low_power_in && (5'(i) < lvl_hi);
    end
    unique case (s_reg.st)
      ST_IDLE: begin
      end
      ST_CLEAR: begin
        s_next.clr_idx = s_reg.clr_idx + 5'h01;
        if (s_reg.clr_idx == 5'h1F) begin
          s_next.st = (s_reg.dly == 16'h0000) ? ST_WAIT : ST_DELAY;
        end
      end
      ST_DELAY: begin
        s_next.dly = s_reg.dly - 16'h0001;
        if (s_reg.dly == 16'h0001) begin
          s_next.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if ((s_reg.tick == TICK_DECIDE) && measure) begin
          s_next.conv_start = 1'b1;
          s_next.conv_sel = s_reg.slot;
          s_next.gpio_sel = s_reg.gpio_idx;
          s_next.st = ST_MEAS;
        end
      end
      ST_MEAS: begin
        if (sample_valid_in) begin
          s_next.sample = (s_reg.slot == `SLOT_DIE) ? die_sat(sample_data_in)
            : sample_data_in;
          s_next.wr_idx = res_idx;
          s_next.fstate = filt_rdata;
          s_next.wr_filt = (is_cell && s_reg.cell_lpf)
            || ((s_reg.slot == `SLOT_BUSBAR) && s_reg.bb_lpf);
          s_next.st = ST_STORE;
        end else if (boundary) begin
          s_next.st = ST_WAIT;
        end
      end
      ST_STORE: begin
        // result memory takes the word this cycle
        s_next.st = ST_WAIT;
        if (s_reg.wr_filt) begin
          s_next.primed[pidx] = 1'b1;
        end
        if (s_reg.wr_idx == `SLOT_DIE) begin
          s_next.die_corr = s_reg.sample;
          s_next.die_corr_v = 1'b1;
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
    if (running) begin
      s_next.tick = s_reg.tick + TW'(1);
      if (boundary) begin
        s_next.tick = '0;
        s_next.slot = s_reg.slot + 5'h01;
        if (s_reg.slot == `SLOT_LAST) begin
          s_next.slot = `SLOT_DIE;
          s_next.gpio_idx = s_reg.gpio_idx + 3'h1;
          s_next.rr_cnt = s_reg.rr_cnt + 4'h1;
          if ((s_reg.mode == `MODE_BURST) && (s_reg.rr_cnt == `RR_BURST_LAST)) begin
            s_next.st = ST_IDLE;
          end
        end
      end
    end
    // register bus
    if (acc) begin
      s_next.pready = 1'b1;
      s_next.prdata = 32'h0000_0000;
      if (res_page) begin
        if (pwrite_in) begin
          s_next.pslverr = 1'b1;
        end else if (!paddr_in[2]) begin
          s_next.prdata = {24'h00_0000, res_rdata[15:8]};
          s_next.hold_v = 1'b1;
          s_next.hold_idx = paddr_in[7:3];
          s_next.hold_byte = res_rdata[7:0];
        end else if (s_reg.hold_v && (s_reg.hold_idx == paddr_in[7:3])) begin
          s_next.prdata = {24'h00_0000, s_reg.hold_byte};
          s_next.hold_v = 1'b0;
        end else begin
          s_next.prdata = {24'h00_0000, res_rdata[7:0]};
        end
      end else begin
        unique case (paddr_in)
          `OFS_CTRL: begin
            if (pwrite_in) begin
              s_next.sw_ctrl = {pwdata_in[`CTRL_BB_LPF:`CTRL_MODE_LSB], 1'b0};
            end
            s_next.prdata = {27'h000_0000, s_reg.sw_ctrl};
          end
          `OFS_CONF: begin
            if (pwrite_in) begin
              s_next.sw_conf = pwdata_in[`CONF_DLY_MSB:0];
            end
            s_next.prdata = {18'h0_0000, s_reg.sw_conf};
          end
          `OFS_ACTIVE: begin
            if (pwrite_in) begin
              s_next.sw_active = pwdata_in[3:0];
            end
            s_next.prdata = {28'h000_0000, s_reg.sw_active};
          end
          `OFS_GPIOCFG: begin
            if (pwrite_in) begin
              s_next.sw_gpio = pwdata_in[7:0];
            end
            s_next.prdata = {24'h00_0000, s_reg.sw_gpio};
          end
          `OFS_STATUS: begin
            s_next.pslverr = pwrite_in;
            s_next.prdata = {16'h0000, running, s_reg.rr_cnt, s_reg.gpio_idx,
              3'h0, s_reg.slot};
          end
          default: begin
            s_next.pslverr = 1'b1;
          end
        endcase
      end
    end
    // start command latches the run settings; main control only
    if (go_wr) begin
      s_next.mode = pwdata_in[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
      s_next.cell_lpf = pwdata_in[`CTRL_CELL_LPF]
        && (pwdata_in[`CTRL_MODE_MSB:`CTRL_MODE_LSB] == `MODE_CONT);
      s_next.bb_lpf = pwdata_in[`CTRL_BB_LPF]
        && (pwdata_in[`CTRL_MODE_MSB:`CTRL_MODE_LSB] == `MODE_CONT);
      s_next.cell_cut = cut_clamp(s_reg.sw_conf[`CONF_CELL_MSB:`CONF_CELL_LSB]);
      s_next.bb_cut = cut_clamp(s_reg.sw_conf[`CONF_BB_MSB:`CONF_BB_LSB]);
      s_next.dly = 16'(s_reg.sw_conf[`CONF_DLY_MSB:`CONF_DLY_LSB]) * 16'(`DLY_UNIT_CYCLES);
      s_next.hi_cell = lvl_hi;
      s_next.gpio_en = s_reg.sw_gpio;
      s_next.slot = `SLOT_DIE;
      s_next.tick = '0;
      s_next.rr_cnt = 4'h0;
      s_next.gpio_idx = 3'h0;
      s_next.clr_idx = 5'h00;
      s_next.primed = '0;
      s_next.st = ST_IDLE;
      if ((pwdata_in[`CTRL_MODE_MSB:`CTRL_MODE_LSB] == `MODE_BURST)
          || (pwdata_in[`CTRL_MODE_MSB:`CTRL_MODE_LSB] == `MODE_CONT)) begin
        s_next.st = ST_CLEAR;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pready_out = s_reg.pready;
  assign prdata_out = s_reg.prdata;
  assign pslverr_out = s_reg.pslverr;
  assign conv_start_out = s_reg.conv_start;
  assign conv_sel_out = s_reg.conv_sel;
  assign gpio_sel_out = s_reg.gpio_sel;
  assign level_shift_en_out = s_reg.lvl_en;
  assign die_temp_corr_out = s_reg.die_corr;
  assign die_temp_corr_valid_out = s_reg.die_corr_v;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  property p_slot_step;
    (boundary && (s_reg.slot != `SLOT_LAST) && !go_wr) |=>
      (s_reg.slot == $past(s_reg.slot) + 5'h01) && (s_reg.tick == '0);
  endproperty
  a_slot_step: assert property (p_slot_step) else $error("slot did not advance");

  property p_gpio_adv;
    (boundary && (s_reg.slot == `SLOT_LAST) && !go_wr && (s_reg.mode == `MODE_CONT)) |=>
      (s_reg.slot == `SLOT_DIE) && (s_reg.gpio_idx == $past(s_reg.gpio_idx) + 3'h1);
  endproperty
  a_gpio_adv: assert property (p_gpio_adv) else $error("gpio index not advanced");

  property p_clear_val;
    (s_reg.st == ST_CLEAR) |-> res_we && (res_wdata == `RESULT_DEFAULT);
  endproperty
  a_clear_val: assert property (p_clear_val) else $error("clear wrote non default");

  property p_no_inactive;
    ((s_reg.st == ST_STORE) && (s_reg.wr_idx >= `SLOT_CELL1) && (s_reg.wr_idx <= `SLOT_CELL16))
      |-> ((s_reg.wr_idx - 5'h01) <= s_reg.hi_cell);
  endproperty
  a_no_inactive: assert property (p_no_inactive) else $error("inactive cell written");

  property p_die_sat;
    ((s_reg.st == ST_STORE) && (s_reg.wr_idx == `SLOT_DIE)) |->
      ($signed(res_wdata) <= DIE_CODE_MAX) && ($signed(res_wdata) >= DIE_CODE_MIN);
  endproperty
  a_die_sat: assert property (p_die_sat) else $error("die result out of range");

  property p_skip;
    ((s_reg.st == ST_WAIT) && (s_reg.tick == TICK_DECIDE) && !measure && !go_wr) |=>
      !conv_start_out ##1 !conv_start_out;
  endproperty
  a_skip: assert property (p_skip) else $error("skipped slot converted");

  property p_lock;
    (s_reg.hold_v && !res_rd && !go_wr) |=> s_reg.hold_v && $stable(s_reg.hold_byte);
  endproperty
  a_lock: assert property (p_lock) else $error("held low byte changed");

  property p_level;
    low_power_in |=> (level_shift_en_out == 16'h0000);
  endproperty
  a_level: assert property (p_level) else $error("level shifter on in low power");

  property p_burst_end;
    (boundary && (s_reg.slot == `SLOT_LAST) && (s_reg.mode == `MODE_BURST)
      && (s_reg.rr_cnt == `RR_BURST_LAST) && !go_wr) |=> (s_reg.st == ST_IDLE);
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("burst did not stop");

  property p_filter_mode;
    (s_reg.cell_lpf || s_reg.bb_lpf) |-> (s_reg.mode == `MODE_CONT);
  endproperty
  a_filter_mode: assert property (p_filter_mode) else $error("filter outside continuous");
endmodule // main_adc_round_robin_lpf

// ==== sample_ram.sv ====
/*
  Simple one-write one-read memory with registered read data.
  Assumes write and read share mclk_in; contents are undefined until written.
*/
`timescale 1ns/100ps
module sample_ram #(
  parameter int W = 16,
  parameter int AW = 5
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [W-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [W-1:0] rd_data_out
);
  logic [W-1:0] mem_reg [2**AW];

  always_ff @(posedge mclk_in) begin
    if (wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem_reg[rd_addr_in];
    end
  end
endmodule // sample_ram

// ==== tb_top.sv ====
/* self-checking bench of the main converter sequencer.
   assumes the front end model and a short slot time. */
`timescale 1ns/100ps
module tb_top;
  logic mclk_in = 1'b0, nrst_in = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, sv, cs, low_pwr = 1'b0, e, cv;
  logic [15:0] sd, lse, corr, r, die_val = 16'h0010, fe_step = 16'h0000;
  logic [4:0] sel;
  logic [2:0] gsel;
  int fail_count = 0, n_compared = 0, cyc = 0, n_starts = 0;
  typedef struct {logic [4:0] idx; logic [15:0] exp;} row_t;
  row_t rows [9] = '{'{5'h00, 16'h0010}, '{5'h01, 16'h015A}, '{5'h02, 16'h025A},
    '{5'h07, 16'h075A}, '{5'h08, 16'h8000}, '{5'h11, 16'h8000}, '{5'h12, 16'h125A},
    '{5'h18, 16'h135A}, '{5'h1F, 16'h135A}};
  logic [15:0] dv [2] = '{16'h7FFF, 16'h8001};
  logic [15:0] de [2] = '{16'h7000, 16'hC800};

  main_adc_round_robin_lpf #(.SLOT_CYC(16)) main_adc_round_robin_lpf_inst (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
    .prdata_out(prdata), .pslverr_out(pslverr), .sample_valid_in(sv),
    .sample_data_in(sd), .low_power_in(low_pwr), .conv_start_out(cs),
    .conv_sel_out(sel), .gpio_sel_out(gsel), .level_shift_en_out(lse),
    .die_temp_corr_out(corr), .die_temp_corr_valid_out(cv));
  front_end_model front_end_model_inst (.mclk_in(mclk_in), .conv_start_in(cs),
    .conv_sel_in(sel), .die_val_in(die_val), .step_in(fe_step), .sample_valid_out(sv),
    .sample_data_out(sd));

  always #2.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cyc++;
    if (cs === 1'b1)
      n_starts++;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      fail_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd_res(input logic [4:0] idx);
    apb(1'b0, {4'h1, idx, 3'h0}, 32'h0);
    r[15:8] = q[7:0];
    apb(1'b0, {4'h1, idx, 3'h4}, 32'h0);
    r[7:0] = q[7:0];
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask

  initial begin
    wait_cyc(8);
    nrst_in <= 1'b1;
    apb(1'b1, 12'h008, 32'h6);
    apb(1'b1, 12'h00C, 32'hFF);
    apb(1'b1, 12'h004, 32'h0);
    n_starts = 0;
    apb(1'b1, 12'h000, 32'h3);
    wait_cyc(3300);
    chk("starts", 32'h50, 32'(n_starts));
    chk("shifters", 32'h3F, {16'h0, lse});
    chk("gpio_sel", 32'h7, {29'h0, gsel});
    for (int i = 0; i < 9; i++) begin
      rd_res(rows[i].idx);
      chk("result", {16'h0, rows[i].exp}, {16'h0, r});
    end
    apb(1'b0, 12'h010, 32'h0);
    chk("running", 32'h0, {31'h0, q[15]});
    apb(1'b0, 12'hFFC, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    die_val <= 16'h0111;
    apb(1'b1, 12'h000, 32'h1D);
    wait_cyc(450);
    rd_res(5'h12);
    chk("busbar", 32'h125A, {16'h0, r});
    rd_res(5'h02);
    chk("cell1", 32'h025A, {16'h0, r});
    apb(1'b0, 12'h100, 32'h0);
    die_val <= 16'h0122;
    wait_cyc(400);
    apb(1'b0, 12'h104, 32'h0);
    chk("frozen_low", 32'h11, {24'h0, q[7:0]});
    apb(1'b0, 12'h104, 32'h0);
    chk("live_low", 32'h22, {24'h0, q[7:0]});
    for (int i = 0; i < 2; i++) begin
      die_val <= dv[i];
      wait_cyc(400);
      rd_res(5'h00);
      chk("die", {16'h0, de[i]}, {16'h0, r});
      chk("die_corr", {15'h0, 1'b1, de[i]}, {15'h0, cv, corr});
    end
    low_pwr <= 1'b1;
    wait_cyc(3);
    chk("shifters", 32'h0, {16'h0, lse});
    low_pwr <= 1'b0;
    apb(1'b0, 12'h010, 32'h0);
    chk("running", 32'h1, {31'h0, q[15]});
    // restart with a start delay, cell cutoff 1 and bus bar cutoff 0, then one input step
    apb(1'b1, 12'h004, 32'h101);
    apb(1'b1, 12'h000, 32'h1D);
    wait_cyc(100);
    apb(1'b0, 12'h010, 32'h0);
    chk("delay_run", 32'h0, {31'h0, q[15]});
    wait_cyc(496);
    fe_step <= 16'h0100;
    wait_cyc(330);
    rd_res(5'h12);
    chk("busbar_step", 32'h12DA, {16'h0, r});
    rd_res(5'h02);
    chk("cell1_step", 32'h029A, {16'h0, r});
    apb(1'b1, 12'h000, 32'h1);
    wait_cyc(400);
    apb(1'b0, 12'h010, 32'h0);
    chk("running", 32'h0, {31'h0, q[15]});
    // reset in the middle of a continuous run
    apb(1'b1, 12'h000, 32'h5);
    wait_cyc(300);
    nrst_in <= 1'b0;
    wait_cyc(2);
    chk("reset_out", 32'h0, {lse[14:0], cv, corr});
    nrst_in <= 1'b1;
    wait_cyc(2);
    chk("shifters", 32'hFFFF, {16'h0, lse});
    apb(1'b0, 12'h010, 32'h0);
    chk("status", 32'h0, q);
    end_of_test();
  end
endmodule // tb_top
